// ### conv_pkg.sv
// Purpose: Shared constants for the converter sequencing block
// Assumes: Wishbone classic slave, 32-bit data, one register per word
// Notes: Offsets are byte addresses
package conv_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_INSEL = 8'h08;
	localparam logic [7:0] OFS_RES_LOW = 8'h0C;
	localparam logic [7:0] OFS_RES_HIGH = 8'h10;
	localparam logic [7:0] OFS_POWER = 8'h14;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CA_PRESC_LSB = 0;
	localparam int CA_FLAG = 4;
	localparam int CA_AUTO = 5;
	localparam int CA_START = 6;
	localparam int CA_ENABLE = 7;
	localparam int IS_CHAN_LSB = 0;
	localparam int IS_LEFT = 5;
	localparam int IS_REF_LSB = 6;
	localparam int PW_REDUCE = 0;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic PW_RESET = 1'b1;
	localparam logic [2:0] TS_RESET = 3'h0;
	localparam logic [2:0] TS_FREE_RUN = 3'h0;
	// ****************************************
	// Timing counts, in converter clock cycles
	// ****************************************
	localparam logic [4:0] CONV_NORMAL = 5'h0D;
	localparam logic [4:0] CONV_FIRST = 5'h19;
	localparam logic [4:0] SAMPLE_NORMAL = 5'h01;
	localparam logic [4:0] SAMPLE_FIRST = 5'h0D;
	localparam int RES_BITS = 10;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} conv_state_t;
endpackage

// ### conv_prescaler.sv
// Purpose: Converter clock prescaler, one-cycle enable out
// Assumes: Held in reset while clear is high
// Notes: Divide by 2,2,4,8,16,32,64,128 per select
`timescale 1ns/1ns
module conv_prescaler (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [6:0] cnt_q;
	logic [6:0] mask;

	always_comb begin
		mask = (sel == 3'h0) ? 7'h01 : 7'((8'h01 << sel) - 8'h01);
	end

	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			cnt_q <= 7'h00;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 7'h01;
			tick <= ((cnt_q & mask) == mask);
		end
	end
endmodule

// ### conv_sar.sv
// Purpose: Successive approximation register, one bit per step
// Assumes: Comparator input is high when analog input exceeds the trial level
// Notes: Trial code drives the internal DAC
`timescale 1ns/1ns
module conv_sar (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic step,
	input wire logic cmp_above,
	output logic [9:0] trial,
	output logic done
);
	logic [9:0] bit_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trial <= 10'h000;
			bit_q <= 10'h000;
			done <= 1'b0;
		end else if (load) begin
			trial <= 10'h200;
			bit_q <= 10'h200;
			done <= 1'b0;
		end else if (step && bit_q != 10'h000) begin
			trial <= (cmp_above ? trial : (trial & ~bit_q)) | (bit_q >> 1);
			bit_q <= bit_q >> 1;
			done <= (bit_q == 10'h001);
		end
	end
endmodule

// ### conv_control.sv
// Purpose: Sequencing of a 10-bit successive approximation converter
// Assumes: Wishbone classic slave; trigger inputs synchronous to CLOCK
// Notes: Analog parts sit outside; this block drives selects and SAR code
//
// Operation
// RULE1 - Ten-bit code by successive approximation
// RULE2 - Power reduce bit blocks converter operation
// RULE3 - Selections apply only once enabled
// RULE4 - Channel field picks pin, ground, bandgap
// RULE5 - Reference field picks supply, 1.1V, external
// RULE6 - Right adjust by default, left optional
// RULE7 - Software reads low byte then high
// RULE8 - Low byte read blocks result updates
// RULE9 - High byte read removes the block
// RULE10 - Completion flag set even if discarded
// RULE11 - Start bit held until conversion ends
// RULE12 - Channel change waits for conversion end
// RULE13 - Auto-trigger uses selected trigger source
// RULE14 - Trigger edge resets prescaler, starts conversion
// RULE15 - High trigger level alone starts nothing
// RULE16 - Edges during conversion are ignored
// RULE17 - Trigger flags set regardless of enables
// RULE18 - Software clears trigger flag before reuse
// RULE19 - Own flag as trigger runs free
// RULE20 - Start bit works with auto-trigger
// RULE21 - Start bit reads one while converting
// RULE22 - Software disables converter before sleep
// RULE23 - Thirteen cycles, first one twenty-five
// RULE24 - Prescaler held reset while disabled
// RULE25 - Completion writes result, flag, clears start
// RULE26 - Low byte bits 7:0, left shifts six
`timescale 1ns/1ns
module conv_control (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// Trigger sources, index 0 is unused (own flag)
	input wire logic [7:0] TRIGGER_IN,
	// Analog front end
	input wire logic CMP_ABOVE,
	output logic [9:0] DAC_CODE,
	output logic [3:0] CHANNEL_SELECT,
	output logic [1:0] REFERENCE_SELECT,
	output logic SAMPLE_HOLD,
	output logic ANALOG_ON
);
	// ****************************************
	// Registers
	// ****************************************
	logic conv_enable_q;
	logic conv_start_q;
	logic auto_trigger_enable_q;
	logic conv_complete_flag_q;
	logic [2:0] prescaler_select_q;
	logic [2:0] trigger_source_select_q;
	logic [3:0] channel_select_q;
	logic left_adjust_result_q;
	logic [1:0] reference_select_q;
	logic conv_power_reduce_q;
	logic [9:0] result_q;
	logic result_lock_q;
	logic first_q;
	logic trig_prev_q;
	logic [4:0] cyc_q;
	logic [4:0] len_q;
	conv_pkg::conv_state_t state_q;
	logic [3:0] chan_act_q;
	logic [1:0] ref_act_q;

	logic tick;
	logic sar_done;
	logic [9:0] sar_code;
	logic trig_sel;
	logic trig_edge;
	logic wr;
	logic rd;
	logic start_req;
	logic complete;
	logic active;
	logic [15:0] adj;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] adjust(input logic [9:0] r, input logic left);
		adjust = left ? {r, 6'h00} : {6'h00, r};
	endfunction

	function automatic logic hit(input logic [7:0] ofs);
		hit = wr && ADR_I == ofs && SEL_I[0];
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	assign wr = CYC_I && STB_I && !ACK_O && WE_I;
	assign rd = CYC_I && STB_I && !ACK_O && !WE_I;
	assign active = conv_enable_q && !conv_power_reduce_q; // RULE2
	assign complete = (state_q == conv_pkg::ST_CONV) && tick && cyc_q == len_q;

	always_comb begin
		trig_sel = TRIGGER_IN[trigger_source_select_q];
		if (trigger_source_select_q == conv_pkg::TS_FREE_RUN) begin
			trig_sel = conv_complete_flag_q; // RULE17
		end
	end
	// Own flag: every completion restarts; others need a fresh edge
	assign trig_edge = auto_trigger_enable_q && active && // RULE13
		((trigger_source_select_q == conv_pkg::TS_FREE_RUN) ? complete : // RULE19
		(trig_sel && !trig_prev_q)); // RULE15
	// Process form so the decode also follows the bus signals read inside hit
	always_comb begin
		start_req = hit(conv_pkg::OFS_CTRL_A) && DAT_I[conv_pkg::CA_START] && active; // RULE20
	end
	assign adj = adjust(result_q, left_adjust_result_q); // RULE6

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else begin
			ACK_O <= CYC_I && STB_I && !ACK_O;
			DAT_O <= 32'h0000_0000;
			if (rd) begin
				case (ADR_I)
				conv_pkg::OFS_CTRL_A: DAT_O[7:0] <= {conv_enable_q, conv_start_q, // RULE21
					auto_trigger_enable_q, conv_complete_flag_q, 1'b0, prescaler_select_q};
				conv_pkg::OFS_CTRL_B: DAT_O[2:0] <= trigger_source_select_q;
				conv_pkg::OFS_INSEL: DAT_O[7:0] <= {reference_select_q, left_adjust_result_q,
					1'b0, channel_select_q};
				conv_pkg::OFS_RES_LOW: DAT_O[7:0] <= adj[7:0];
				conv_pkg::OFS_RES_HIGH: DAT_O[7:0] <= adj[15:8];
				conv_pkg::OFS_POWER: DAT_O[0] <= conv_power_reduce_q;
				default: DAT_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			conv_enable_q <= 1'b0;
			auto_trigger_enable_q <= 1'b0;
			prescaler_select_q <= 3'h0;
			trigger_source_select_q <= conv_pkg::TS_RESET;
			channel_select_q <= 4'h0;
			left_adjust_result_q <= 1'b0;
			reference_select_q <= 2'h0;
			conv_power_reduce_q <= conv_pkg::PW_RESET;
		end else begin
			if (hit(conv_pkg::OFS_CTRL_A)) begin
				conv_enable_q <= DAT_I[conv_pkg::CA_ENABLE];
				auto_trigger_enable_q <= DAT_I[conv_pkg::CA_AUTO];
				prescaler_select_q <= DAT_I[conv_pkg::CA_PRESC_LSB +: 3];
			end
			if (hit(conv_pkg::OFS_CTRL_B)) begin
				trigger_source_select_q <= DAT_I[2:0];
			end
			if (hit(conv_pkg::OFS_INSEL)) begin
				channel_select_q <= DAT_I[conv_pkg::IS_CHAN_LSB +: 4]; // RULE4
				left_adjust_result_q <= DAT_I[conv_pkg::IS_LEFT];
				reference_select_q <= DAT_I[conv_pkg::IS_REF_LSB +: 2]; // RULE5
			end
			if (hit(conv_pkg::OFS_POWER)) begin
				conv_power_reduce_q <= DAT_I[conv_pkg::PW_REDUCE];
			end
		end
	end

	// ****************************************
	// Start bit and completion flag
	// ****************************************
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			conv_start_q <= 1'b0;
		end else if (!active) begin
			conv_start_q <= 1'b0;
		end else if (start_req || trig_edge) begin
			conv_start_q <= 1'b1; // RULE11
		end else if (complete) begin
			conv_start_q <= 1'b0; // RULE25
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			conv_complete_flag_q <= 1'b0;
		end else if (complete) begin
			conv_complete_flag_q <= 1'b1; // RULE10
		end else if (hit(conv_pkg::OFS_CTRL_A) && DAT_I[conv_pkg::CA_FLAG]) begin
			conv_complete_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_sel;
		end
	end

	// ****************************************
	// Conversion sequencer
	// ****************************************
	conv_prescaler u_presc (
		.clk(CLOCK),
		.rst_n(RST_N),
		.clear(!active || (trig_edge && state_q != conv_pkg::ST_CONV)), // RULE14 RULE24
		.sel(prescaler_select_q),
		.tick(tick)
	);

	conv_sar u_sar (
		.clk(CLOCK),
		.rst_n(RST_N),
		.load(state_q == conv_pkg::ST_CONV && tick && cyc_q == len_q - 5'h0B),
		.step(state_q == conv_pkg::ST_CONV && tick && cyc_q > len_q - 5'h0B),
		.cmp_above(CMP_ABOVE),
		.trial(sar_code),
		.done(sar_done)
	);

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state_q <= conv_pkg::ST_IDLE;
			cyc_q <= 5'h00;
			len_q <= conv_pkg::CONV_NORMAL;
			first_q <= 1'b1;
		end else if (!active) begin
			state_q <= conv_pkg::ST_IDLE;
			first_q <= 1'b1;
		end else begin
			case (state_q)
			conv_pkg::ST_IDLE: begin
				if (start_req || trig_edge) begin
					state_q <= conv_pkg::ST_WAIT;
				end
			end
			conv_pkg::ST_WAIT: begin
				if (tick) begin
					state_q <= conv_pkg::ST_CONV;
					cyc_q <= 5'h01;
					len_q <= first_q ? conv_pkg::CONV_FIRST : conv_pkg::CONV_NORMAL; // RULE23
					first_q <= 1'b0;
				end
			end
			conv_pkg::ST_CONV: begin
				// Edges mid-conversion are dropped, not queued
				if (complete) begin
					// A start written in the completing cycle must not be lost
					state_q <= (trig_edge || start_req) ? conv_pkg::ST_WAIT : // RULE16
						conv_pkg::ST_IDLE;
				end else if (tick) begin
					cyc_q <= cyc_q + 5'h01;
				end
			end
			default: state_q <= conv_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Result and read lock
	// ****************************************
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			result_lock_q <= 1'b0;
		end else if (rd && ADR_I == conv_pkg::OFS_RES_HIGH) begin
			result_lock_q <= 1'b0; // RULE9
		end else if (rd && ADR_I == conv_pkg::OFS_RES_LOW) begin
			result_lock_q <= 1'b1; // RULE8
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			result_q <= 10'h000;
		end else if (complete && !result_lock_q) begin
			result_q <= sar_code; // RULE1 RULE25 RULE26
		end
	end

	// ****************************************
	// Analog outputs
	// ****************************************
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			chan_act_q <= 4'h0;
			ref_act_q <= 2'h0;
			ANALOG_ON <= 1'b0;
			SAMPLE_HOLD <= 1'b0;
			DAC_CODE <= 10'h000;
		end else begin
			ANALOG_ON <= active;
			// Selection tracks until start, locks until last cycle
			if (active && (state_q != conv_pkg::ST_CONV || cyc_q == len_q)) begin
				chan_act_q <= channel_select_q; // RULE3 RULE12
				ref_act_q <= reference_select_q;
			end
			// first_q is already cleared here, so the length tells a first conversion
			SAMPLE_HOLD <= state_q == conv_pkg::ST_CONV && cyc_q <= ((len_q == conv_pkg::CONV_FIRST) ?
				conv_pkg::SAMPLE_FIRST : conv_pkg::SAMPLE_NORMAL); // RULE23
			DAC_CODE <= sar_code;
		end
	end
	assign CHANNEL_SELECT = chan_act_q;
	assign REFERENCE_SELECT = ref_act_q;

	// ****************************************
	// Checks
	// ****************************************
	a_power_blocks: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE2
		conv_power_reduce_q |=> state_q == conv_pkg::ST_IDLE)
		else $error("conversion while power reduced");
	a_start_clears: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE25
		complete |=> conv_start_q == $past(trig_edge || start_req))
		else $error("start bit not cleared");
	a_flag_sets: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE10
		complete |=> conv_complete_flag_q)
		else $error("completion flag missing");
	a_lock_holds: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE8
		complete && result_lock_q |=> $stable(result_q))
		else $error("locked result changed");
	a_unlock_high: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE9
		rd && ADR_I == conv_pkg::OFS_RES_HIGH |=> !result_lock_q)
		else $error("lock not removed");
	a_start_busy: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE21
		state_q == conv_pkg::ST_CONV |-> conv_start_q)
		else $error("start bit low while busy");
	a_disabled_presc: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE24
		!active ##1 !active |-> !tick)
		else $error("prescaler ran while disabled");
	a_len_values: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE23
		state_q == conv_pkg::ST_CONV |-> len_q == 5'h0D || len_q == 5'h19)
		else $error("bad conversion length");
endmodule

// ### conv_control_test.sv
// Purpose: Self-checking bench for conv_control
// Assumes: Comparator modelled as analog level plus half an LSB
// Notes: Prescaler at divide by two keeps conversions short
`timescale 1ns/1ns
module conv_control_test;
	logic CLOCK = 1'b0;
	logic RST_N = 1'b0;
	logic CYC_I = 1'b0;
	logic STB_I = 1'b0;
	logic WE_I = 1'b0;
	logic [7:0] ADR_I = 8'h00;
	logic [3:0] SEL_I = 4'h0;
	logic [31:0] DAT_I = 32'h0;
	logic [7:0] TRIGGER_IN = 8'h00;
	logic [31:0] DAT_O;
	logic ACK_O;
	logic CMP_ABOVE;
	logic [9:0] DAC_CODE;
	logic [3:0] CHANNEL_SELECT;
	logic [1:0] REFERENCE_SELECT;
	logic SAMPLE_HOLD;
	logic ANALOG_ON;
	logic [9:0] level = 10'h000;
	logic [31:0] rd;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int t0;
	int tf;
	int tn;
	conv_control u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I),
		.WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
		.ACK_O(ACK_O), .TRIGGER_IN(TRIGGER_IN), .CMP_ABOVE(CMP_ABOVE),
		.DAC_CODE(DAC_CODE), .CHANNEL_SELECT(CHANNEL_SELECT),
		.REFERENCE_SELECT(REFERENCE_SELECT), .SAMPLE_HOLD(SAMPLE_HOLD),
		.ANALOG_ON(ANALOG_ON));
	assign CMP_ABOVE = (DAC_CODE <= level);
	always #20 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic summarize;
		$display("counts: %0d checked, %0d failed", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLOCK);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= we;
		ADR_I <= a;
		DAT_I <= d;
		SEL_I <= 4'hF;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (ACK_O !== 1'b1 && n < 20);
		rd = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
		WE_I <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			summarize();
		end
	endtask
	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask
	task automatic wait_flag;
		int n;
		n = 0;
		do begin
			wb(1'b0, conv_pkg::OFS_CTRL_A, 32'h0);
			n++;
		end while (rd[conv_pkg::CA_FLAG] !== 1'b1 && n < 100);
		if (n >= 100) begin
			fail_count++;
			summarize();
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rchk("power", conv_pkg::OFS_POWER, {31'h0, conv_pkg::PW_RESET});
		rchk("ctrl_b", conv_pkg::OFS_CTRL_B, {29'h0, conv_pkg::TS_RESET});
		rchk("unmapped", 8'h20, 32'h0);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'h80);
		repeat (4) @(posedge CLOCK);
		check("analog_on", {31'h0, ANALOG_ON}, 32'h0);
		check("hold_idle", {31'h0, SAMPLE_HOLD}, 32'h0);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'h00);
		$display("test reset done");
	endtask
	task automatic t_single;
		wb(1'b1, conv_pkg::OFS_POWER, 32'h0);
		wb(1'b1, conv_pkg::OFS_INSEL, 32'h43);
		check("chan_off", {28'h0, CHANNEL_SELECT}, 32'h0);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'h80);
		repeat (2) @(posedge CLOCK);
		check("chan_on", {28'h0, CHANNEL_SELECT}, 32'h3);
		check("ref_on", {30'h0, REFERENCE_SELECT}, 32'h1);
		check("analog_on", {31'h0, ANALOG_ON}, 32'h1);
		level = 10'h2A5;
		t0 = cyc;
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hC0);
		wb(1'b0, conv_pkg::OFS_CTRL_A, 32'h0);
		check("start_busy", {31'h0, rd[conv_pkg::CA_START]}, 32'h1);
		check("hold_first", {31'h0, SAMPLE_HOLD}, 32'h1);
		wait_flag();
		tf = cyc - t0;
		check("start_done", {31'h0, rd[conv_pkg::CA_START]}, 32'h0);
		rchk("low_right", conv_pkg::OFS_RES_LOW, 32'hA5);
		rchk("high_right", conv_pkg::OFS_RES_HIGH, 32'h2);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'h90);
		$display("test single done");
	endtask
	task automatic t_left_lock;
		wb(1'b1, conv_pkg::OFS_INSEL, 32'h63);
		level = 10'h1CB;
		t0 = cyc;
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hC0);
		wait_flag();
		tn = cyc - t0;
		check("first_len", {31'h0, (tf - tn >= 16 && tf - tn <= 32)}, 32'h1);
		rchk("low_left", conv_pkg::OFS_RES_LOW, 32'hC0);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'h90);
		level = 10'h3FF;
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hC0);
		wait_flag();
		check("flag_lost", {31'h0, rd[conv_pkg::CA_FLAG]}, 32'h1);
		rchk("high_lock", conv_pkg::OFS_RES_HIGH, 32'h72);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hD0);
		wait_flag();
		rchk("low_new", conv_pkg::OFS_RES_LOW, 32'hC0);
		rchk("high_new", conv_pkg::OFS_RES_HIGH, 32'hFF);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'h90);
		$display("test left and lock done");
	endtask
	task automatic t_channel;
		for (int i = 0; i < 16; i++) begin
			wb(1'b1, conv_pkg::OFS_INSEL, {24'h0, i[1:0], 2'b00, i[3:0]});
			repeat (2) @(posedge CLOCK);
			check("chan_sel", {28'h0, CHANNEL_SELECT}, {28'h0, i[3:0]});
			check("ref_sel", {30'h0, REFERENCE_SELECT}, {30'h0, i[1:0]});
		end
		wb(1'b1, conv_pkg::OFS_INSEL, 32'h03);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hC0);
		wb(1'b1, conv_pkg::OFS_INSEL, 32'h05);
		check("chan_hold", {28'h0, CHANNEL_SELECT}, 32'h3);
		wait_flag();
		repeat (2) @(posedge CLOCK);
		check("chan_after", {28'h0, CHANNEL_SELECT}, 32'h5);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'h90);
		$display("test channel done");
	endtask
	task automatic t_auto;
		wb(1'b1, conv_pkg::OFS_CTRL_B, 32'h2);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hA0);
		level = 10'h155;
		TRIGGER_IN <= 8'h04;
		wait_flag();
		rchk("low_auto", conv_pkg::OFS_RES_LOW, 32'h55);
		rchk("high_auto", conv_pkg::OFS_RES_HIGH, 32'h01);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hB0);
		repeat (150) @(posedge CLOCK);
		rchk("held_high", conv_pkg::OFS_CTRL_A, 32'hA0);
		TRIGGER_IN <= 8'h00;
		@(posedge CLOCK);
		TRIGGER_IN <= 8'h04;
		repeat (8) @(posedge CLOCK);
		TRIGGER_IN <= 8'h00;
		repeat (2) @(posedge CLOCK);
		TRIGGER_IN <= 8'h04;
		wait_flag();
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hB0);
		repeat (150) @(posedge CLOCK);
		rchk("edge_busy", conv_pkg::OFS_CTRL_A, 32'hA0);
		TRIGGER_IN <= 8'h00;
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hE0);
		wb(1'b0, conv_pkg::OFS_CTRL_A, 32'h0);
		check("start_auto", {31'h0, rd[conv_pkg::CA_START]}, 32'h1);
		wait_flag();
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hB0);
		$display("test auto done");
	endtask
	task automatic t_free;
		wb(1'b1, conv_pkg::OFS_CTRL_B, {29'h0, conv_pkg::TS_FREE_RUN});
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hE0);
		wait_flag();
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'hB0);
		wait_flag();
		check("start_free", {31'h0, rd[conv_pkg::CA_START]}, 32'h1);
		wb(1'b1, conv_pkg::OFS_CTRL_A, 32'h00);
		repeat (2) @(posedge CLOCK);
		check("analog_off", {31'h0, ANALOG_ON}, 32'h0);
		$display("test free done");
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge CLOCK);
		RST_N <= 1'b1;
		t_reset();
		t_single();
		t_left_lock();
		t_channel();
		t_auto();
		t_free();
		summarize();
	end
endmodule
